/* File: shared/nvc_pkg.sv */
/*
 * Package for the nonvolatile SRAM host controller: key addresses, timing figures
 * and derived cycle counts, and the command and state enumerations.
 * Assumes a 25 MHz system clock; every timing but CYCLE_ALLOW_US is re-derived from the clock period.
 */
package nvc_pkg;

   // ----------------------------------------------------------------
   // Clock and geometry
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int ADDR_WIDTH    = 13;
   localparam int DATA_WIDTH    = 8;

   // ----------------------------------------------------------------
   // Key sequence addresses
   // ----------------------------------------------------------------
   localparam logic [12:0] KEY_ADDR0      = 13'h0000;
   localparam logic [12:0] KEY_ADDR1      = 13'h1555;
   localparam logic [12:0] KEY_ADDR2      = 13'h0AAA;
   localparam logic [12:0] KEY_ADDR3      = 13'h1FFF;
   localparam logic [12:0] KEY_ADDR4      = 13'h10F0;
   localparam logic [12:0] KEY_STORE_LAST = 13'h0F0F;
   localparam logic [12:0] KEY_RECALL_LAST = 13'h0F0E;

   // ----------------------------------------------------------------
   // Timing figures in their own units
   // ----------------------------------------------------------------
   localparam int ACCESS_NS          = 55;    // Slowest read access and write pulse.
   localparam int STORE_DURATION_MS  = 10;
   localparam int CYCLE_ALLOW_US     = 1;
   localparam int INHIBIT_RELEASE_NS = 700;
   localparam int STORE_PULSE_NS     = 15;
   localparam int BUSY_REPLY_NS      = 300;
   localparam int POWERUP_RECALL_US  = 550;
   localparam int RECALL_DURATION_US = 20;

   // ----------------------------------------------------------------
   // Derived cycle counts (least times round up)
   // ----------------------------------------------------------------
   localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STORE_PULSE_CYC = (STORE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_REPLY_CYC  = (BUSY_REPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_CYC     = (INHIBIT_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECALL_CYC      = (RECALL_DURATION_US * 1000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int STORE_CYC       = (STORE_DURATION_MS * 1000000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int POWERUP_CYC     = (POWERUP_RECALL_US * 1000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int TIMER_WIDTH     = 24;

   // ----------------------------------------------------------------
   // Commands and states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      NVC_CMD_READ,
      NVC_CMD_WRITE,
      NVC_CMD_SW_STORE,
      NVC_CMD_SW_RECALL,
      NVC_CMD_HW_STORE
   } nvc_cmd_t;

   typedef enum {
      NVC_POWERUP,
      NVC_IDLE,
      NVC_SETUP,
      NVC_STROBE,
      NVC_GAP,
      NVC_WAIT_NV,
      NVC_HSB_PULSE,
      NVC_HSB_WAIT_LOW,
      NVC_HSB_WAIT_HIGH,
      NVC_RECOVER
   } nvc_state_t;

endpackage : nvc_pkg

/* File: hw/nvc_sync.sv */
/*
 * Two flip-flop synchroniser for one level from a pin.
 * Assumes the input may change at any time relative to clk.
 */
module nvc_sync
   import nvc_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b1
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic async_in,
   output logic      sync_out
);

   // ----------------------------------------------------------------
   // Synchroniser
   // ----------------------------------------------------------------
   logic stage1;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1   <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // nvc_sync

/* File: hw/nvc_host.sv */
/*
 * Host controller for an 8192 x 8 nonvolatile SRAM: reads, writes, software store
 * and recall key sequences, hardware store requests on the shared busy line.
 * Assumes the memory pins connect directly; store_busy_n has an external pull-up.
 */
// Operation
// - address held stable through whole write.
// - output enable stays high during writes.
// - key addresses issued in exact order.
// - write enable high for all key cycles.
// - request pulse held low at least 15 ns.
// - busy line only pulled low, never high.
module nvc_host
   import nvc_pkg::*;
#(
   parameter int STORE_CYCLES   = STORE_CYC,
   parameter int POWERUP_CYCLES = POWERUP_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  cmd_valid,
   input  wire nvc_cmd_t              cmd_op,
   input  wire logic [ADDR_WIDTH-1:0] cmd_addr,
   input  wire logic [DATA_WIDTH-1:0] cmd_wdata,
   output logic                       cmd_ready,
   output logic                       rsp_valid,
   output logic [DATA_WIDTH-1:0]      rsp_rdata,
   output logic                       nv_busy,
   output logic [ADDR_WIDTH-1:0]      address_pins,
   output logic                       chip_enable_n,
   output logic                       write_enable_n,
   output logic                       output_enable_n,
   input  wire logic [DATA_WIDTH-1:0] data_pins_in,
   output logic [DATA_WIDTH-1:0]      data_pins_out,
   output logic                       data_pins_oe_n,
   input  wire logic                  store_busy_n_in,
   output logic                       store_busy_n_out,
   output logic                       store_busy_n_oe_n
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic                  busy_pin_n;
   logic [DATA_WIDTH-1:0] data_sync;

   nvc_sync #(.RESET_VALUE(1'b1)) u_busy_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (store_busy_n_in),
      .sync_out (busy_pin_n)
   );

   // Read data is only sampled long after it settles, so per-bit sync is safe.
   for (genvar i = 0; i < DATA_WIDTH; i++) begin : g_dsync
      nvc_sync #(.RESET_VALUE(1'b0)) u_dsync (
         .clk      (clk),
         .reset_n  (reset_n),
         .async_in (data_pins_in[i]),
         .sync_out (data_sync[i])
      );
   end

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   nvc_state_t             state, next_state;
   nvc_cmd_t               op, next_op;
   logic [TIMER_WIDTH-1:0] timer, next_timer;
   logic [2:0]             key_idx, next_key_idx;
   logic [ADDR_WIDTH-1:0]  addr, next_addr;
   logic [DATA_WIDTH-1:0]  wdata, next_wdata;
   logic [DATA_WIDTH-1:0]  rdata, next_rdata;
   logic                   rvalid, next_rvalid;
   logic                   ce_n, next_ce_n;
   logic                   we_n, next_we_n;
   logic                   oe_n, next_oe_n;
   logic                   drive, next_drive;
   logic                   pull, next_pull;

   // Key address for the current step of a sequence.
   function automatic logic [ADDR_WIDTH-1:0] key_addr(input logic [2:0] idx,
                                                      input nvc_cmd_t   kind);
      unique case (idx)
         3'h0:    key_addr = KEY_ADDR0;
         3'h1:    key_addr = KEY_ADDR1;
         3'h2:    key_addr = KEY_ADDR2;
         3'h3:    key_addr = KEY_ADDR3;
         3'h4:    key_addr = KEY_ADDR4;
         default: key_addr = (kind == NVC_CMD_SW_STORE) ? KEY_STORE_LAST : KEY_RECALL_LAST;
      endcase
   endfunction

   // Next-state logic for the whole pin sequencer.
   always_comb begin
      next_state   = state;
      next_op      = op;
      next_timer   = (timer != '0) ? timer - 1'b1 : timer;
      next_key_idx = key_idx;
      next_addr    = addr;
      next_wdata   = wdata;
      next_rdata   = rdata;
      next_rvalid  = 1'b0;
      next_ce_n    = ce_n;
      next_we_n    = we_n;
      next_oe_n    = oe_n;
      next_drive   = drive;
      next_pull    = pull;
      unique case (state)
         NVC_POWERUP: begin
            if (timer == '0) begin
               next_state = NVC_IDLE;
            end
         end
         NVC_IDLE: begin
            if (!busy_pin_n) begin
               next_state = NVC_HSB_WAIT_HIGH;
            end else if (cmd_valid) begin
               next_op      = cmd_op;
               next_addr    = cmd_addr;
               next_wdata   = cmd_wdata;
               next_key_idx = 3'h0;
               if (cmd_op == NVC_CMD_HW_STORE) begin
                  next_pull  = 1'b1;
                  next_timer = TIMER_WIDTH'(STORE_PULSE_CYC);
                  next_state = NVC_HSB_PULSE;
               end else begin
                  if (cmd_op == NVC_CMD_SW_STORE || cmd_op == NVC_CMD_SW_RECALL) begin
                     next_addr = KEY_ADDR0;
                  end
                  next_state = NVC_SETUP;
               end
            end
         end
         NVC_SETUP: begin
            next_ce_n  = 1'b0;
            next_timer = TIMER_WIDTH'(ACCESS_CYC + 2);
            if (op == NVC_CMD_WRITE) begin
               next_we_n  = 1'b0;
               next_drive = 1'b1;
            end else if (op == NVC_CMD_READ) begin
               next_oe_n = 1'b0;
            end
            next_state = NVC_STROBE;
         end
         NVC_STROBE: begin
            if (timer == '0) begin
               next_ce_n  = 1'b1;
               next_we_n  = 1'b1;
               next_oe_n  = 1'b1;
               next_state = NVC_GAP;
               if (op == NVC_CMD_READ) begin
                  next_rdata  = data_sync;
                  next_rvalid = 1'b1;
               end
            end
         end
         NVC_GAP: begin
            next_drive = 1'b0;
            if (op == NVC_CMD_SW_STORE || op == NVC_CMD_SW_RECALL) begin
               if (key_idx == 3'h5) begin
                  next_timer = (op == NVC_CMD_SW_STORE) ? TIMER_WIDTH'(STORE_CYCLES)
                                                        : TIMER_WIDTH'(RECALL_CYC);
                  next_state = NVC_WAIT_NV;
               end else begin
                  next_key_idx = key_idx + 3'h1;
                  next_addr    = key_addr(key_idx + 3'h1, op);
                  next_state   = NVC_SETUP;
               end
            end else begin
               next_state = NVC_IDLE;
            end
         end
         // wait out the store or recall
         NVC_WAIT_NV: begin
            if (timer == '0) begin
               next_state = NVC_IDLE;
            end
         end
         NVC_HSB_PULSE: begin
            if (timer == '0) begin
               next_pull  = 1'b0;
               next_timer = TIMER_WIDTH'(BUSY_REPLY_CYC + 2);
               next_state = NVC_HSB_WAIT_LOW;
            end
         end
         NVC_HSB_WAIT_LOW: begin
            if (!busy_pin_n) begin
               next_state = NVC_HSB_WAIT_HIGH;
            end else if (timer == '0) begin
               next_timer = TIMER_WIDTH'(RELEASE_CYC);
               next_state = NVC_RECOVER;
            end
         end
         NVC_HSB_WAIT_HIGH: begin
            if (busy_pin_n) begin
               next_timer = TIMER_WIDTH'(RELEASE_CYC);
               next_state = NVC_RECOVER;
            end
         end
         NVC_RECOVER: begin
            if (timer == '0) begin
               next_state = NVC_IDLE;
            end
         end
         default: next_state = NVC_IDLE;
      endcase
   end

   // Registers of the sequencer.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state   <= NVC_POWERUP;
         op      <= NVC_CMD_READ;
         timer   <= TIMER_WIDTH'(POWERUP_CYCLES);
         key_idx <= 3'h0;
         addr    <= '0;
         wdata   <= '0;
         rdata   <= '0;
         rvalid  <= 1'b0;
         ce_n    <= 1'b1;
         we_n    <= 1'b1;
         oe_n    <= 1'b1;
         drive   <= 1'b0;
         pull    <= 1'b0;
      end else begin
         state   <= next_state;
         op      <= next_op;
         timer   <= next_timer;
         key_idx <= next_key_idx;
         addr    <= next_addr;
         wdata   <= next_wdata;
         rdata   <= next_rdata;
         rvalid  <= next_rvalid;
         ce_n    <= next_ce_n;
         we_n    <= next_we_n;
         oe_n    <= next_oe_n;
         drive   <= next_drive;
         pull    <= next_pull;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Pins come from registers except store_busy_n_out, which is tied low; ready and busy status are decoded from state and the synchronised busy line.
   assign cmd_ready         = (state == NVC_IDLE) && busy_pin_n;
   assign rsp_valid         = rvalid;
   assign rsp_rdata         = rdata;
   assign nv_busy           = (state != NVC_IDLE) || !busy_pin_n;
   assign address_pins      = addr;
   assign chip_enable_n     = ce_n;
   // key cycles keep write enable high
   assign write_enable_n    = we_n;
   assign output_enable_n   = oe_n;
   assign data_pins_out     = wdata;
   assign data_pins_oe_n    = !drive;
   assign store_busy_n_out  = 1'b0;
   assign store_busy_n_oe_n = !pull;

endmodule // nvc_host

/* File: dv/nvc_host_props.sv */
/* Concurrent checks on the nonvolatile SRAM host: strobes, requests and the busy line.
   Assumes it is bound to nvc_host and sees only that module's ports. */
module nvc_host_props
   import nvc_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire logic                  cmd_valid,
   input wire nvc_cmd_t              cmd_op,
   input wire logic                  cmd_ready,
   input wire logic                  rsp_valid,
   input wire logic                  nv_busy,
   input wire logic [ADDR_WIDTH-1:0] address_pins,
   input wire logic                  chip_enable_n,
   input wire logic                  write_enable_n,
   input wire logic                  output_enable_n,
   input wire logic [DATA_WIDTH-1:0] data_pins_out,
   input wire logic                  data_pins_oe_n,
   input wire logic                  store_busy_n_in,
   input wire logic                  store_busy_n_out,
   input wire logic                  store_busy_n_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Requests taken at the command port and the strobes they cause.
   sequence s_take(nvc_cmd_t op); cmd_valid && cmd_ready && cmd_op == op; endsequence
   sequence s_rd_strobe; (!chip_enable_n && !output_enable_n && write_enable_n) [*4]; endsequence
   sequence s_wr_strobe; (!chip_enable_n && !write_enable_n && output_enable_n) [*4]; endsequence

   a_read_cycle: assert property (s_take(NVC_CMD_READ) |-> ##[1:3] s_rd_strobe ##[1:3] rsp_valid)
      else $error("read strobe or answer out of place");
   a_write_cycle: assert property (s_take(NVC_CMD_WRITE) |-> ##[1:3] s_wr_strobe ##1 write_enable_n)
      else $error("write strobe out of place");
   a_strobe_width: assert property ($fell(chip_enable_n) |-> !chip_enable_n [*5] ##1 chip_enable_n)
      else $error("chip enable strobe width wrong");
   a_write_hold: assert property (!write_enable_n |-> $stable(address_pins) && $stable(data_pins_out))
      else $error("address or data moved during write");
   a_write_no_oe: assert property (!write_enable_n |-> output_enable_n && !data_pins_oe_n)
      else $error("output enable low or data undriven in write");
   a_key_reads: assert property (s_take(NVC_CMD_SW_STORE) |-> ##1 write_enable_n [*8])
      else $error("write enable low in key sequence");
   a_hw_pulse: assert property (s_take(NVC_CMD_HW_STORE) |-> ##[1:3] !store_busy_n_oe_n)
      else $error("store request pulse missing");
   a_pull_low_only: assert property (!store_busy_n_oe_n |-> !store_busy_n_out)
      else $error("busy line driven high");
   a_ready_busy_line: assert property (!store_busy_n_in [*3] |=> !cmd_ready)
      else $error("ready while busy line low");
   a_idle_released: assert property (!nv_busy |-> chip_enable_n && data_pins_oe_n)
      else $error("pins active while idle");
endmodule // nvc_host_props

bind nvc_host nvc_host_props props_u (
   .clk, .reset_n, .cmd_valid, .cmd_op, .cmd_ready, .rsp_valid, .nv_busy, .address_pins,
   .chip_enable_n, .write_enable_n, .output_enable_n, .data_pins_out, .data_pins_oe_n,
   .store_busy_n_in, .store_busy_n_out, .store_busy_n_oe_n
);

/* File: dv/nvc_mem_model.sv */
/* Behavioural model of the 8192 x 8 SRAM with a shadow nonvolatile copy.
   Assumes an external pull-up on the busy line and a released bus that shows no old value. */
module nvc_mem_model
   import nvc_pkg::*;
#(
   parameter int HOLD_NS    = 1000,
   parameter int STORE_NS   = 1500,
   parameter int RECALL_NS  = 19000,
   parameter int POWERUP_NS = 500
) (
   input  wire logic [12:0] address_pins,
   input  wire logic        chip_enable_n,
   input  wire logic        write_enable_n,
   input  wire logic        output_enable_n,
   input  wire logic [7:0]  data_bus,
   input  wire logic        store_busy_n,
   output logic [7:0]       dq_drive,
   output logic             busy_pull = 1'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [8192];
   logic [7:0]  nv [8192] = '{default: 8'h5A};
   logic [7:0]  last = 8'h00;
   logic        inhibit = 1'h1;
   logic        dirty = 1'h0;
   int          key_idx = 0;
   logic [12:0] key [5] = '{KEY_ADDR0, KEY_ADDR1, KEY_ADDR2, KEY_ADDR3, KEY_ADDR4};
   wire         reading = !chip_enable_n && !output_enable_n && write_enable_n && store_busy_n
                          && !inhibit;
   wire         writing = !chip_enable_n && !write_enable_n && store_busy_n && !inhibit;

   // drive the addressed byte only in a clean read.
   assign dq_drive = reading ? mem[address_pins] : ~last;
   always @(reading or address_pins) if (reading) last = mem[address_pins];

   // the byte is taken as the write ends; it breaks a key.
   always @(negedge writing) if (!inhibit) begin
      mem[address_pins] = data_bus;
      dirty = 1'h1;
      key_idx = 0;
   end

   // store erases then programs, recall clears then copies.
   task automatic nv_cycle(input logic is_store);
      key_idx = 0;
      inhibit = 1'h1;
      if (is_store) begin
         busy_pull = 1'h1;
         nv = '{default: 8'hFF};
         #(STORE_NS) nv = mem;
         busy_pull = 1'h0;
      end else begin
         mem = '{default: 8'h00};
         #(RECALL_NS) mem = nv;
      end
      dirty = 1'h0;
      inhibit = 1'h0;
   endtask

   // keys advance on chip enable falls, output enable ignored.
   always @(negedge chip_enable_n) begin
      if (!write_enable_n || inhibit) key_idx = 0;
      else if (key_idx == 5 && address_pins inside {KEY_STORE_LAST, KEY_RECALL_LAST})
         nv_cycle(address_pins == KEY_STORE_LAST);
      else if (key_idx < 5 && address_pins == key[key_idx]) key_idx++;
      else key_idx = (address_pins == KEY_ADDR0) ? 1 : 0;
   end

   // external low starts a conditional store.
   always @(negedge store_busy_n) if (!busy_pull && !inhibit) begin
      #20 busy_pull = 1'h1;
      #(HOLD_NS - 20) inhibit = 1'h1;
      if (dirty) nv_cycle(1'h1);
      busy_pull = 1'h0;
      inhibit = 1'h1;
      wait (store_busy_n === 1'h1);
      #600 inhibit = 1'h0;
   end

   // power-up recall fills the SRAM from the shadow copy.
   initial #(POWERUP_NS) begin
      mem = nv;
      inhibit = 1'h0;
   end
endmodule // nvc_mem_model

/* File: dv/nvc_host_tb_top.sv */
/* Self-checking bench for nvc_host against the memory model.
   Assumes the safe short store and power-up counts set below. */
module nvc_host_tb_top
   import nvc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD_NS  = 1000;
   localparam int STORE_NS = 1500;
   logic                  clk = 1'h0;
   logic                  reset_n = 1'h0;
   logic                  cmd_valid = 1'h0;
   nvc_cmd_t              cmd_op = NVC_CMD_READ;
   logic [ADDR_WIDTH-1:0] cmd_addr = '0;
   logic [DATA_WIDTH-1:0] cmd_wdata = '0;
   logic                  cmd_ready, rsp_valid, nv_busy, chip_enable_n, write_enable_n;
   logic                  output_enable_n, data_pins_oe_n, store_busy_n_out, store_busy_n_oe_n;
   logic                  busy_pull, hsb_line;
   logic [ADDR_WIDTH-1:0] address_pins;
   logic [DATA_WIDTH-1:0] rsp_rdata, data_pins_out, dq_drive, data_bus;
   int                    failures = 0;
   int                    n_checks = 0;

   // Pulled-up busy line and the shared data bus.
   assign hsb_line = ((!store_busy_n_oe_n && !store_busy_n_out) || busy_pull) ? 1'h0 : 1'h1;
   assign data_bus = data_pins_oe_n ? dq_drive : data_pins_out;

   nvc_host #(.STORE_CYCLES(50), .POWERUP_CYCLES(20)) dut_u (
      .clk, .reset_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid,
      .rsp_rdata, .nv_busy, .address_pins, .chip_enable_n, .write_enable_n, .output_enable_n,
      .data_pins_in(data_bus), .data_pins_out, .data_pins_oe_n, .store_busy_n_in(hsb_line),
      .store_busy_n_out, .store_busy_n_oe_n);
   nvc_mem_model #(.HOLD_NS(HOLD_NS), .STORE_NS(STORE_NS)) mem_u (
      .address_pins, .chip_enable_n, .write_enable_n, .output_enable_n, .data_bus,
      .store_busy_n(hsb_line), .dq_drive, .busy_pull);

   // Clock at 25 MHz.
   initial forever #20 clk = ~clk;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic give_up(input string what);
      failures++;
      $display("wrong value at %0t: %s timed out", $time, what);
      stop_test();
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Waits for ready, then holds one request for the taking edge.
   task automatic issue(input nvc_cmd_t op, input logic [12:0] a, input logic [7:0] d);
      int i;
      for (i = 0; i < 2000 && cmd_ready !== 1'h1; i++) @(negedge clk);
      if (i == 2000) give_up("ready");
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_valid = 1'h1;
      @(negedge clk);
      cmd_valid = 1'h0;
   endtask

   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      int i;
      issue(NVC_CMD_READ, a, 8'h00);
      for (i = 0; i < 20 && rsp_valid !== 1'h1; i++) @(negedge clk);
      if (i == 20) give_up("read answer");
      check(rsp_rdata, exp, "read data");
   endtask

   // Requests a hardware store, counts the low time and the recovery.
   task automatic hw_store(output int n);
      int i;
      issue(NVC_CMD_HW_STORE, 13'h0000, 8'h00);
      for (i = 0; i < 10 && hsb_line !== 1'h0; i++) @(negedge clk);
      if (i == 10) give_up("busy low");
      for (n = 0; n < 300 && hsb_line === 1'h0; n++) @(negedge clk);
      if (n == 300) give_up("busy line");
      for (i = 0; i < 100 && cmd_ready !== 1'h1; i++) @(negedge clk);
      if (i == 100) give_up("recovery");
      check(8'(i >= RELEASE_CYC), 8'h01, "recovery wait");
   endtask

   task automatic t_basic;
      logic [12:0] a [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
      check({7'h00, chip_enable_n}, 8'h01, "idle chip enable");
      rd(13'h0123, 8'h5A);
      foreach (a[i]) issue(NVC_CMD_WRITE, a[i], 8'hA0 + 8'(i));
      foreach (a[i]) rd(a[i], 8'hA0 + 8'(i));
      $display("test basic done");
   endtask

   task automatic t_soft;
      issue(NVC_CMD_WRITE, 13'h0100, 8'hC3);
      issue(NVC_CMD_SW_STORE, 13'h0000, 8'h00);
      issue(NVC_CMD_WRITE, 13'h0100, 8'h11);
      rd(13'h0100, 8'h11);
      issue(NVC_CMD_SW_RECALL, 13'h0000, 8'h00);
      rd(13'h0100, 8'hC3);
      $display("test soft done");
   endtask

   task automatic t_hard;
      int lo_clean;
      int lo_dirty;
      hw_store(lo_clean);
      issue(NVC_CMD_WRITE, 13'h0200, 8'h77);
      hw_store(lo_dirty);
      issue(NVC_CMD_WRITE, 13'h0200, 8'h88);
      issue(NVC_CMD_SW_RECALL, 13'h0000, 8'h00);
      rd(13'h0200, 8'h77);
      check(8'(lo_clean < HOLD_NS / 40 + 3), 8'h01, "skipped store length");
      check(8'(lo_dirty >= (HOLD_NS + STORE_NS) / 40 - 2), 8'h01, "store length");
      $display("test hard done");
   endtask

   task automatic t_reset;
      issue(NVC_CMD_READ, 13'h0040, 8'h00);
      @(negedge clk);
      reset_n = 1'h0;
      @(negedge clk);
      check({5'h00, chip_enable_n, output_enable_n, data_pins_oe_n}, 8'h07, "reset pins");
      check({7'h00, cmd_ready}, 8'h00, "reset ready");
      repeat (3) @(negedge clk);
      reset_n = 1'h1;
      rd(13'h0100, 8'hC3);
      $display("test reset done");
   endtask

   // Main sequence.
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'h1;
      t_basic();
      t_soft();
      t_hard();
      t_reset();
      stop_test();
   end
endmodule // nvc_host_tb_top
